// *** dv/test_watchdog_timer_unit.sv ***
`include "wdt_map.vh"

module test_watchdog_timer_unit;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------------
    // Stimulus and observation
    // ----------------------------------------------------------------
    logic        mclk_i = 0, nrst_i = 0, stop_mode_i = 0, wait_mode_i = 0;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic [4:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire         s_axi_rvalid, irq_o, wdt_reset_o;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    integer      errors = 0, n_compared = 0, seed, m;
    logic [31:0] d, c1, c2;
    logic [1:0]  r;

    always #20 mclk_i = ~mclk_i;

    wdt_unit DUT
    (
        .mclk_i        (mclk_i),
        .nrst_i        (nrst_i),
        .stop_mode_i   (stop_mode_i),
        .wait_mode_i   (wait_mode_i),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .irq_o         (irq_o),
        .wdt_reset_o   (wdt_reset_o)
    );

    task automatic close_out;
        $display("errors=%0d compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic rng(input [31:0] got, input integer lo, hi, input string s);
        n_compared++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            errors++;
            $display("[ERR] %0t %s got %0h", $time, s, got);
        end
    endtask

    task automatic wr(input [4:0] a, input [31:0] v, output [1:0] rr);
        logic ta, tw, tb;
        @(posedge mclk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        tb = 0;
        for (int k = 0; k < 40 && !tb; k++)
        begin
            #1;
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            rr = s_axi_bresp;
            @(posedge mclk_i);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        if (!tb) rng(1, 0, 0, "write hang");
        if (!tb) close_out();
    endtask

    task automatic rd(input [4:0] a, output [31:0] v, output [1:0] rr);
        logic ta, tb;
        @(posedge mclk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        tb = 0;
        for (int k = 0; k < 40 && !tb; k++)
        begin
            #1;
            ta = s_axi_arvalid && s_axi_arready;
            tb = s_axi_rvalid;
            v = s_axi_rdata;
            rr = s_axi_rresp;
            @(posedge mclk_i);
            if (ta) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        if (!tb) rng(1, 0, 0, "read hang");
        if (!tb) close_out();
    endtask

    // Counter steps over n prescaler periods, one extra for phase
    task automatic rate(input integer dv, n);
        logic [31:0] a, b;
        logic [1:0]  q;
        rd(`WDT_OFF_COUNT, a, q);
        repeat (n * dv) @(posedge mclk_i);
        rd(`WDT_OFF_COUNT, b, q);
        rng({17'h0, a[14:0] - b[14:0]}, n, n + 1, "rate");
    endtask

    initial
    begin
        seed = 44;
        repeat (2) @(posedge mclk_i);
        nrst_i <= 1'b1;
        wr(`WDT_OFF_REFRESH, $random(seed), r);
        repeat (40) @(posedge mclk_i);
        rd(`WDT_OFF_COUNT, d, r);
        rng(d, 32'h7fff, 32'h7fff, "idle count");
        rd(`WDT_OFF_PMODE1, d, r);
        rng(d, 0, 0, "mode reset value");
        wr(`WDT_OFF_START, $random(seed), r);
        rd(`WDT_OFF_COUNT, d, r);
        rng(d[15], 1, 1, "running");
        rd(`WDT_OFF_START, d, r);
        rng(d, 0, 0, "start reads zero");
        rate(16, 40);
        wr(`WDT_OFF_CTRL, 32'h80, r);
        rate(128, 10);
        for (m = 0; m < 2; m++)
        begin
            stop_mode_i <= (m == 0);
            wait_mode_i <= (m == 1);
            rd(`WDT_OFF_COUNT, c1, r);
            repeat (400 + $random(seed) % 64) @(posedge mclk_i);
            rd(`WDT_OFF_COUNT, c2, r);
            rng(c2, c1, c1, "held");
            stop_mode_i <= 1'b0;
            wait_mode_i <= 1'b0;
            rd(`WDT_OFF_COUNT, d, r);
            rng({17'h0, c2[14:0] - d[14:0]}, 0, 1, "resume");
            rate(128, 2);
        end
        wr(`WDT_OFF_REFRESH, $random(seed), r);
        rd(`WDT_OFF_COUNT, d, r);
        rng(d, 32'hfffe, 32'hffff, "refresh");
        rate(128, 3);
        wr(`WDT_OFF_PMODE1, 32'h4, r);
        wr(`WDT_OFF_PMODE1, 32'h0, r);
        rd(`WDT_OFF_PMODE1, d, r);
        rng(d[2], 1, 1, "select sticks");
        wr(`WDT_OFF_MASK, 32'h3, r);
        rd(`WDT_OFF_MASK, d, r);
        rng(d, 3, 3, "mask");
        wr(`WDT_OFF_STATUS, 32'h3, r);
        @(negedge mclk_i);
        rng({31'h0, irq_o}, 0, 0, "irq idle");
        rd(5'h1c, d, r);
        rng(r, 2, 2, "bad read resp");
        wr(5'h02, 32'h1, r);
        rng(r, 2, 2, "bad write resp");
        close_out();
    end
endmodule // test_watchdog_timer_unit

bind wdt_unit wdt_unit_assertions u_chk (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .stop_mode_i(stop_mode_i), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .irq_o(irq_o), .wdt_reset_o(wdt_reset_o));

// *** dv/wdt_unit_assertions.sv ***
module wdt_unit_assertions
(
    // Watched ports
    input wire        mclk_i,
    input wire        nrst_i,
    input wire        stop_mode_i,
    input wire        s_axi_awready,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [4:0]  s_axi_araddr,
    input wire        s_axi_rvalid,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        irq_o,
    input wire        wdt_reset_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);
    wire ar_go = s_axi_arvalid && s_axi_arready;

    a_idle_after_reset: assert property (
        $rose(nrst_i) |-> (!irq_o && !wdt_reset_o) [*8])
        else $error("output after reset");
    a_reset_one_pulse: assert property (
        wdt_reset_o |=> !wdt_reset_o)
        else $error("reset pulse too long");
    a_stop_no_under: assert property (
        stop_mode_i [*3] |-> !wdt_reset_o)
        else $error("underflow while held");
    a_start_reads_zero: assert property (
        ar_go && s_axi_araddr == 5'h08
        |=> s_axi_rvalid && s_axi_rdata == 32'h0)
        else $error("start reads");
    a_rd_bad_addr: assert property (ar_go && s_axi_araddr > 5'h18
        |=> s_axi_rvalid && s_axi_rresp == 2'h2) else $error("no slverr");
    a_rd_answer: assert property (ar_go |=> s_axi_rvalid)
        else $error("late read answer");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("ar taken during rvalid");
    a_w_refused: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during bvalid");
    a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");

    cover property (ar_go && s_axi_araddr == 5'h18);
    cover property (stop_mode_i [*3]);
    cover property (s_axi_bvalid && s_axi_bready);
endmodule // wdt_unit_assertions

// *** src/wdt_map.vh ***
`ifndef WDT_MAP_VH
`define WDT_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define WDT_OFF_CTRL      5'h00
`define WDT_OFF_PMODE1    5'h04
`define WDT_OFF_START     5'h08
`define WDT_OFF_REFRESH   5'h0c
`define WDT_OFF_STATUS    5'h10
`define WDT_OFF_MASK      5'h14
`define WDT_OFF_COUNT     5'h18

// ----------------------------------------------------------------
// Field positions and constants
// ----------------------------------------------------------------
`define WDT_CTRL_PRESEL_BIT   7
`define WDT_PM1_RSTSEL_BIT    2
`define WDT_ST_UNDER_BIT      0
`define WDT_ST_RESET_BIT      1
`define WDT_CNT_W             15
`define WDT_CNT_FULL          15'h7fff
`define WDT_PRE_W             7
`define WDT_DIV_LO            7'h0f
`define WDT_DIV_HI            7'h7f
`define WDT_RESP_OKAY         2'h0
`define WDT_RESP_SLVERR       2'h2

`endif

// *** src/wdt_prescaler.v ***
`include "wdt_map.vh"

module wdt_prescaler
(
    // Clock and reset
    input  wire       mclk_i,
    input  wire       nrst_i,
    // Control
    input  wire       run_i,
    input  wire       hold_i,
    input  wire       div_hi_i,
    // Tick
    output reg        tick_o
);

    reg  [`WDT_PRE_W-1:0] pre_r;
    wire [`WDT_PRE_W-1:0] limit;

    assign limit = div_hi_i ? `WDT_DIV_HI : `WDT_DIV_LO;

    always @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pre_r <= {`WDT_PRE_W{1'b0}};
        end
        else
        begin
            if (!run_i)
            begin
                pre_r <= {`WDT_PRE_W{1'b0}};
            end
            else if (!hold_i)
            begin
                if (pre_r >= limit)
                begin
                    pre_r <= {`WDT_PRE_W{1'b0}};
                end
                else
                begin
                    pre_r <= pre_r + 7'h01;
                end
            end
        end
    end

    // Tick in the cycle it is used, so a hold starting then keeps it
    always @*
    begin
        tick_o = run_i && !hold_i && (pre_r >= limit);
    end

endmodule // wdt_prescaler

// *** src/wdt_unit.v ***
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`include "wdt_map.vh"

module wdt_unit
(
    // Clock and reset
    input  wire        mclk_i,
    input  wire        nrst_i,
    // Power modes
    input  wire        stop_mode_i,
    input  wire        wait_mode_i,
    // AXI4-Lite write address
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [4:0]  s_axi_awaddr,
    // AXI4-Lite write data
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    output reg  [1:0]  s_axi_bresp,
    // AXI4-Lite read address
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    input  wire [4:0]  s_axi_araddr,
    // AXI4-Lite read data
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    // Watchdog outputs
    output wire        irq_o,
    output reg         wdt_reset_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    reg                    aw_got_r;
    reg  [4:0]             aw_addr_r;
    reg                    w_got_r;
    reg  [31:0]            w_data_r;
    reg  [3:0]             w_strb_r;
    reg                    running_r;
    reg                    presel_r;
    reg                    rstsel_r;
    reg  [`WDT_CNT_W-1:0]  cnt_r;
    reg  [1:0]             status_r;
    reg  [1:0]             mask_r;

    wire                   tick;
    wire                   hold;
    wire                   do_wr;
    wire                   wr_ok;
    wire                   start_wr;
    wire                   refresh_wr;
    wire                   underflow;
    wire [1:0]             ev;

    function addr_ok;
        input [4:0] a;
        begin
            addr_ok = (a[1:0] == 2'h0) && (a <= `WDT_OFF_COUNT);
        end
    endfunction

    // ------------------------------------------------------------
    // Bus write side
    // ------------------------------------------------------------
    assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
    assign do_wr         = aw_got_r && w_got_r && !s_axi_bvalid;
    assign wr_ok         = do_wr && addr_ok(aw_addr_r);
    // Only the write itself acts; its data is not looked at
    assign start_wr      = wr_ok && aw_addr_r == `WDT_OFF_START;
    assign refresh_wr    = wr_ok && aw_addr_r == `WDT_OFF_REFRESH;

    always @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            aw_got_r     <= 1'b0;
            aw_addr_r    <= 5'h00;
            w_got_r      <= 1'b0;
            w_data_r     <= 32'h0000_0000;
            w_strb_r     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `WDT_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_r  <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_r  <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (do_wr)
            begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= addr_ok(aw_addr_r) ? `WDT_RESP_OKAY
                                                   : `WDT_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            presel_r <= 1'b0;
            rstsel_r <= 1'b0;
            mask_r   <= 2'h0;
        end
        else if (wr_ok && w_strb_r[0])
        begin
            if (aw_addr_r == `WDT_OFF_CTRL)
            begin
                presel_r <= w_data_r[`WDT_CTRL_PRESEL_BIT];
            end
            // Sticky: a zero never clears it
            if (aw_addr_r == `WDT_OFF_PMODE1 &&
                w_data_r[`WDT_PM1_RSTSEL_BIT])
            begin
                rstsel_r <= 1'b1;
            end
            if (aw_addr_r == `WDT_OFF_MASK)
            begin
                mask_r <= w_data_r[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    assign hold      = stop_mode_i || wait_mode_i;
    assign underflow = running_r && !hold && tick &&
                       cnt_r == {`WDT_CNT_W{1'b0}};

    wdt_prescaler u_pre
    (
        .mclk_i   (mclk_i),
        .nrst_i   (nrst_i),
        .run_i    (running_r),
        .hold_i   (hold),
        .div_hi_i (presel_r),
        .tick_o   (tick)
    );

    always @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            running_r   <= 1'b0;
            cnt_r       <= `WDT_CNT_FULL;
            wdt_reset_o <= 1'b0;
        end
        else
        begin
            wdt_reset_o <= 1'b0;
            if (start_wr)
            begin
                running_r <= 1'b1;
                cnt_r     <= `WDT_CNT_FULL;
            end
            else if (refresh_wr && running_r)
            begin
                cnt_r <= `WDT_CNT_FULL;
            end
            else if (underflow)
            begin
                cnt_r <= `WDT_CNT_FULL;
                // 32768 steps of 16 or 128 clocks per period
                wdt_reset_o <= rstsel_r;
            end
            else if (running_r && !hold && tick)
            begin
                cnt_r <= cnt_r - 15'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------
    assign ev = {underflow && rstsel_r, underflow && !rstsel_r};

    always @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            status_r <= 2'h0;
        end
        else
        begin
            // Set wins over a write-one clear
            if (wr_ok && w_strb_r[0] && aw_addr_r == `WDT_OFF_STATUS)
            begin
                status_r <= (status_r & ~w_data_r[1:0]) | ev;
            end
            else
            begin
                status_r <= status_r | ev;
            end
        end
    end

    assign irq_o = |(status_r & mask_r);

    // ------------------------------------------------------------
    // Bus read side
    // ------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;

    always @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `WDT_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= addr_ok(s_axi_araddr) ? `WDT_RESP_OKAY
                                                  : `WDT_RESP_SLVERR;
            case (s_axi_araddr)
                `WDT_OFF_CTRL:
                    s_axi_rdata <= {24'h0, presel_r, 7'h0};
                `WDT_OFF_PMODE1:
                    s_axi_rdata <= {29'h0, rstsel_r, 2'h0};
                `WDT_OFF_STATUS:
                    s_axi_rdata <= {30'h0, status_r};
                `WDT_OFF_MASK:
                    s_axi_rdata <= {30'h0, mask_r};
                `WDT_OFF_COUNT:
                    s_axi_rdata <= {16'h0000, running_r, cnt_r};
                default:
                    s_axi_rdata <= 32'h0000_0000;
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // wdt_unit
